// ### logic/usart_status.sv
// Status flags, interrupt mask, smart-card NACK control and receive-line filter.
`timescale 1ns/10ps
`include "usart_status_defs.svh"

module usart_status #(
  parameter int unsigned TIMEOUT_W = `TIMEOUT_W,
  parameter int unsigned DIV16     = `SIXTEENTH_DIV
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire usart_status_pkg::reg_req_t   bus_i,
  input  wire usart_status_pkg::line_evt_t  evt_i,
  input  wire usart_status_pkg::cmd_t       cmd_i,
  input  wire logic                         rx_line_i,
  output logic [31:0]                       rdata_o,
  output logic                              irq_o,
  output logic                              nack_drive_o,
  output logic                              rx_filtered_o
);
  import usart_status_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]          mode;
    logic [15:0]          tout_val;
    logic [31:0]          mask;
    logic [31:0]          flags;
    logic                 tout_armed;
    logic                 rx_was_busy;
    logic                 tx_full;
    logic [3:0]           modem_prev;
    logic [2:0]           iter_cnt;
    logic [2:0]           samples;
    logic [7:0]           div_cnt;
    flt_state_t           flt;
    logic                 rx_filt;
    logic                 nack;
    logic                 irq;
    logic [31:0]          rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Majority of three samples.
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Assemble the channel status word from flags and live modem levels.
  function automatic logic [31:0] status_word(input logic [31:0] f, input line_evt_t e);
    logic [31:0] w;
    w = f & `IRQ_BITS;
    w[`BIT_RI]  = e.ring;
    w[`BIT_DSR] = e.set_ready;
    w[`BIT_DCD] = e.carrier;
    w[`BIT_CTS] = e.clear_to_send;
    status_word = w;
  endfunction

  logic        stat_rd;
  logic        is_t0;
  logic        card_mode;
  logic [3:0]  modem_now;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    modem_now = {evt_i.clear_to_send, evt_i.carrier, evt_i.set_ready, evt_i.ring};
    stat_rd   = bus_i.rd && (bus_i.addr == `OFS_CHAN_STAT);
    is_t0     = (st_r.mode[`MODE_HI:`MODE_LO] == `MODE_T0);
    card_mode = is_t0 || (st_r.mode[`MODE_HI:`MODE_LO] == `MODE_T1);

    // Register writes; enable and disable words act only on the set bits.
    if (bus_i.wr) begin
      if (bus_i.addr == `OFS_MODE) begin
        st_nxt.mode = bus_i.wdata & `MODE_USED;
      end else if (bus_i.addr == `OFS_TIMEOUT) begin
        st_nxt.tout_val = bus_i.wdata[15:0];
      end else if (bus_i.addr == `OFS_IRQ_SET) begin
        st_nxt.mask = st_r.mask | (bus_i.wdata & `IRQ_BITS);
      end else if (bus_i.addr == `OFS_IRQ_CLR) begin
        st_nxt.mask = st_r.mask & ~(bus_i.wdata & `IRQ_BITS);
      end
    end

    // Read data, valid in the cycle after the strobe; write-only words read zero.
    st_nxt.rdata = 32'h00000000;
    if (bus_i.rd) begin
      if (bus_i.addr == `OFS_MODE) begin
        st_nxt.rdata = st_r.mode;
      end else if (bus_i.addr == `OFS_TIMEOUT) begin
        st_nxt.rdata = {16'h0000, st_r.tout_val};
      end else if (bus_i.addr == `OFS_IRQ_MASK) begin
        st_nxt.rdata = st_r.mask;
      end else if (bus_i.addr == `OFS_CHAN_STAT) begin
        st_nxt.rdata = status_word(st_r.flags, evt_i);
      end
    end

    // Receiver ready: a disable while busy is remembered so re-enable raises it.
    if (evt_i.rx_enabled && evt_i.rx_busy) begin
      st_nxt.rx_was_busy = 1'b1;
    end
    if (!evt_i.rx_enabled) begin
      st_nxt.flags[`BIT_RX_READY] = 1'b0;
    end else if (evt_i.rx_char_done || st_r.rx_was_busy && !evt_i.rx_busy) begin
      st_nxt.flags[`BIT_RX_READY] = 1'b1;
      st_nxt.rx_was_busy       = 1'b0;
    end else if (evt_i.rx_holding_read) begin
      st_nxt.flags[`BIT_RX_READY] = 1'b0;
      st_nxt.rx_was_busy       = 1'b0;
    end

    // Transmit holding occupancy; a write in the same cycle as a move wins.
    if (evt_i.tx_holding_write) begin
      st_nxt.tx_full = 1'b1;
    end else if (evt_i.tx_to_shift) begin
      st_nxt.tx_full = 1'b0;
    end
    st_nxt.flags[`BIT_TX_FREE] = evt_i.tx_enabled && !st_nxt.tx_full
                               && !evt_i.start_break_cmd;
    st_nxt.flags[`BIT_TX_EMPTY] = evt_i.tx_enabled && !st_nxt.tx_full
                                 && !evt_i.tx_shift_busy;

    // Mirrored DMA channel signals.
    st_nxt.flags[`BIT_RX_DMA_DONE]  = evt_i.rx_dma_done;
    st_nxt.flags[`BIT_TX_DMA_DONE]  = evt_i.tx_dma_done;
    st_nxt.flags[`BIT_TX_BUF_EMPTY] = evt_i.tx_dma_buffer_empty;
    st_nxt.flags[`BIT_RX_BUF_FULL]  = evt_i.rx_dma_buffer_full;

    // Sticky error flags: clear first so a same-cycle event wins.
    if (cmd_i.status_reset_cmd) begin
      st_nxt.flags[`BIT_PAR]   = 1'b0;
      st_nxt.flags[`BIT_FRAME] = 1'b0;
      st_nxt.flags[`BIT_OVR]   = 1'b0;
      st_nxt.flags[`BIT_BRK]   = 1'b0;
    end
    if (evt_i.break_edge) st_nxt.flags[`BIT_BRK] = 1'b1;
    if (evt_i.overrun) st_nxt.flags[`BIT_OVR] = 1'b1;
    if (evt_i.stop_low) st_nxt.flags[`BIT_FRAME] = 1'b1;
    if (evt_i.parity_err) st_nxt.flags[`BIT_PAR] = 1'b1;

    // Time-out: armed by the start command, counted after a character.
    if (cmd_i.start_timeout_cmd) begin
      st_nxt.flags[`BIT_TOUT] = 1'b0;
      st_nxt.tout_armed       = 1'b1;
    end
    if (st_r.tout_armed && evt_i.timeout_hit && st_r.tout_val != 16'h0000) begin
      st_nxt.flags[`BIT_TOUT] = 1'b1;
      st_nxt.tout_armed       = 1'b0;
    end
    if (st_r.tout_val == 16'h0000) begin
      st_nxt.flags[`BIT_TOUT] = 1'b0;
    end

    // Card NACK generation; the pulse lasts one cycle.
    st_nxt.nack = 1'b0;
    if (cmd_i.reset_iterations_cmd && card_mode) begin
      st_nxt.flags[`BIT_ITER] = 1'b0;
      st_nxt.iter_cnt         = 3'h0;
    end
    if (evt_i.parity_err && card_mode && !st_r.mode[`MODE_NACK_INHIBIT]) begin
      if (!st_r.mode[`MODE_NACK_COUNT] || !is_t0) begin
        st_nxt.nack = 1'b1;
      end else if (st_r.iter_cnt < st_r.mode[`MODE_ITER_HI:`MODE_ITER_LO]) begin
        st_nxt.nack     = 1'b1;
        st_nxt.iter_cnt = st_r.iter_cnt + 3'h1;
      end else begin
        st_nxt.flags[`BIT_ITER] = 1'b1;
      end
    end else if (evt_i.rx_char_done && !evt_i.parity_err) begin
      st_nxt.iter_cnt = 3'h0;                                 // Good character ends the run.
    end

    // NACK detected from the card.
    if (cmd_i.reset_nack_cmd) st_nxt.flags[`BIT_NACK] = 1'b0;
    if (evt_i.nack_seen) st_nxt.flags[`BIT_NACK] = 1'b1;

    // Modem change flags: cleared by the status read, a change wins.
    st_nxt.modem_prev = modem_now;
    if (stat_rd) st_nxt.flags[`BIT_CTSC:`BIT_RIC] = 4'h0;
    st_nxt.flags[`BIT_CTSC:`BIT_RIC] = st_nxt.flags[`BIT_CTSC:`BIT_RIC]
                                       | (modem_now ^ st_r.modem_prev);

    // Receive filter sampling at one sixteenth of a bit.
    case (st_r.flt)
      FLT_WAIT: begin
        if (st_r.div_cnt == 8'(DIV16 - 1)) begin
          st_nxt.div_cnt = 8'h00;
          st_nxt.flt     = FLT_TAKE;
        end else begin
          st_nxt.div_cnt = st_r.div_cnt + 8'h01;
        end
      end
      FLT_TAKE: begin
        st_nxt.samples = {st_r.samples[1:0], rx_line_i};
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
        st_nxt.flt     = FLT_WAIT;
      end
      default: st_nxt.flt = FLT_WAIT;
    endcase
    st_nxt.rx_filt = st_r.mode[`MODE_FILTER] ? vote3(st_r.samples) : rx_line_i;

    st_nxt.flags = st_nxt.flags & `IRQ_BITS;
    st_nxt.irq   = |(st_nxt.flags & st_nxt.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset loads the filter samples and output high, so the filtered line idles high.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r         <= '0;
      st_r.samples <= 3'h7;
      st_r.rx_filt <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o       = st_r.rdata;
  assign irq_o         = st_r.irq;
  assign nack_drive_o  = st_r.nack;
  assign rx_filtered_o = st_r.rx_filt;

endmodule

// ### logic/usart_status_defs.svh
// Register offsets, field positions, reset values and constants of the serial status block.
`ifndef USART_STATUS_DEFS_SVH
`define USART_STATUS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_MODE        8'h04
`define OFS_IRQ_SET     8'h08
`define OFS_IRQ_CLR     8'h0C
`define OFS_IRQ_MASK    8'h10
`define OFS_CHAN_STAT   8'h14
`define OFS_TIMEOUT     8'h24

// ----------------------------------------------------------------
// Status and mask bit positions
// ----------------------------------------------------------------
`define BIT_RX_READY    0
`define BIT_TX_FREE     1
`define BIT_BRK         2
`define BIT_RX_DMA_DONE 3
`define BIT_TX_DMA_DONE 4
`define BIT_OVR         5
`define BIT_FRAME       6
`define BIT_PAR         7
`define BIT_TOUT        8
`define BIT_TX_EMPTY    9
`define BIT_ITER        10
`define BIT_TX_BUF_EMPTY 11
`define BIT_RX_BUF_FULL 12
`define BIT_NACK        13
`define BIT_RIC         16
`define BIT_CTSC        19
`define BIT_RI          20
`define BIT_DSR         21
`define BIT_DCD         22
`define BIT_CTS         23

// Maskable source bits: 0..13 and 16..19.
`define IRQ_BITS        32'h000F3FFF

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_LO         0
`define MODE_HI         3
`define MODE_NACK_INHIBIT 20
`define MODE_NACK_COUNT 21
`define MODE_ITER_LO    24
`define MODE_ITER_HI    26
`define MODE_FILTER     28
`define MODE_T0         4'h4
`define MODE_T1         4'h6
`define MODE_RESET      32'h00000000
`define MODE_USED       32'h1737000F

`define TIMEOUT_W       16
`define SIXTEENTH_DIV   16

`endif

// ### logic/usart_status_pkg.sv
// Types shared by the serial status block.
package usart_status_pkg;

  // Register bus request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Events and levels from the receiver, transmitter, DMA channels and modem pins.
  typedef struct packed {
    logic rx_char_done;
    logic rx_holding_read;
    logic rx_enabled;
    logic rx_busy;
    logic tx_holding_write;
    logic tx_to_shift;
    logic tx_shift_busy;
    logic tx_enabled;
    logic start_break_cmd;
    logic break_edge;
    logic overrun;
    logic stop_low;
    logic parity_err;
    logic timeout_hit;
    logic nack_seen;
    logic rx_dma_done;
    logic tx_dma_done;
    logic tx_dma_buffer_empty;
    logic rx_dma_buffer_full;
    logic ring;
    logic set_ready;
    logic carrier;
    logic clear_to_send;
  } line_evt_t;

  // Commands from the control register.
  typedef struct packed {
    logic status_reset_cmd;
    logic start_timeout_cmd;
    logic reset_iterations_cmd;
    logic reset_nack_cmd;
  } cmd_t;

  // Receive filter phase.
  typedef enum logic [0:0] {
    FLT_WAIT = 1'b0,
    FLT_TAKE = 1'b1
  } flt_state_t;

endpackage

// ### testbench/serial_peer.sv
// Far-side model of the serial peer: modem pins, receive line and a card counting NACKs.
`timescale 1ns/10ps
module serial_peer (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] modem_req_i,
  input  wire logic       line_req_i,
  input  wire logic       nack_drive_i,
  output logic [3:0]      modem_o,
  output logic            rx_line_o,
  output int              nacks_o
);
  // The line idles high, as an idle serial line does.
  initial begin
    modem_o   = 4'h0;
    rx_line_o = 1'b1;
    nacks_o   = 0;
  end

  // Pins move one cycle after a request, registered on the core clock.
  always @(posedge core_clk_i) begin
    modem_o   <= modem_req_i;
    rx_line_o <= line_req_i;
    if (nack_drive_i) begin
      nacks_o <= nacks_o + 1;
    end
  end
endmodule

// ### testbench/usart_status_bench.sv
// Self-checking bench of the serial status block.
`timescale 1ns/10ps
`include "usart_status_defs.svh"
module usart_status_bench;
  import usart_status_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  reg_req_t    bus = '0;
  line_evt_t   ev = '0;
  line_evt_t   evw;
  cmd_t        cmd = '0;
  logic [3:0]  modem_req = 4'h0;
  logic        line_req = 1'b1;
  logic [3:0]  modem;
  logic        rx_line;
  logic [31:0] rdata;
  logic        irq;
  logic        nack;
  logic        rx_filt;
  int          nacks;
  int          z;
  int          num_errors = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  // Modem levels come from the peer, everything else from the bench.
  always_comb begin
    evw = ev;
    {evw.ring, evw.set_ready, evw.carrier, evw.clear_to_send} = modem;
  end

  serial_peer peer (.core_clk_i(clk), .modem_req_i(modem_req), .line_req_i(line_req), .nack_drive_i(nack),
    .modem_o(modem), .rx_line_o(rx_line), .nacks_o(nacks));
  usart_status uut (.core_clk_i(clk), .rst_n_i(rst_n), .bus_i(bus), .evt_i(evw), .cmd_i(cmd),
    .rx_line_i(rx_line), .rdata_o(rdata), .irq_o(irq), .nack_drive_o(nack), .rx_filtered_o(rx_filt));

  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bus cycles: one strobe cycle each, read data taken in the cycle after.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(n, e, rdata & m);
  endtask

  task automatic pe(input line_evt_t m);
    @(posedge clk);
    ev <= ev | m;
    @(posedge clk);
    ev <= ev & ~m;
    #1;
  endtask

  task automatic pc(input cmd_t m);
    @(posedge clk);
    cmd <= m;
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc("status at reset", `OFS_CHAN_STAT, 32'hFFFFFFFF, 32'h0);
    wr(`OFS_IRQ_SET, 32'hFFFFFFFF);
    rc("mask all", `OFS_IRQ_MASK, 32'hFFFFFFFF, `IRQ_BITS);
    wr(`OFS_IRQ_CLR, 32'h000F3FDF);
    wr(`OFS_IRQ_CLR, 32'h0);
    wr(`OFS_IRQ_MASK, 32'hFFFF);
    rc("mask view", `OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h20);
    rc("unmapped", 8'hF0, 32'hFFFFFFFF, 32'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
    pe('{break_edge: 1'b1, default: 1'b0});
    pe('{overrun: 1'b1, default: 1'b0});
    pe('{stop_low: 1'b1, default: 1'b0});
    pe('{parity_err: 1'b1, default: 1'b0});
    chk("irq flag", 32'h1, {31'h0, irq});
    rc("sticky", `OFS_CHAN_STAT, 32'hE4, 32'hE4);
    pc('{status_reset_cmd: 1'b1, default: 1'b0});
    rc("sticky cleared", `OFS_CHAN_STAT, 32'hE4, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge clk);
    ev.rx_dma_done <= 1'b1;
    ev.tx_dma_buffer_empty <= 1'b1;
    rc("dma first", `OFS_CHAN_STAT, 32'h1818, 32'h0808);
    @(posedge clk);
    ev.rx_dma_done <= 1'b0;
    ev.tx_dma_buffer_empty <= 1'b0;
    ev.tx_dma_done <= 1'b1;
    ev.rx_dma_buffer_full <= 1'b1;
    rc("dma second", `OFS_CHAN_STAT, 32'h1818, 32'h1010);
    @(posedge clk);
    ev[7:4] <= 4'h0;
    ev.rx_enabled <= 1'b1;
    ev.tx_enabled <= 1'b1;
    pe('{rx_char_done: 1'b1, default: 1'b0});
    rc("rx ready", `OFS_CHAN_STAT, 32'h203, 32'h203);
    pe('{rx_holding_read: 1'b1, default: 1'b0});
    pe('{tx_holding_write: 1'b1, default: 1'b0});
    rc("tx held", `OFS_CHAN_STAT, 32'h203, 32'h0);
    @(posedge clk);
    ev.tx_shift_busy <= 1'b1;
    pe('{tx_to_shift: 1'b1, default: 1'b0});
    rc("tx shifting", `OFS_CHAN_STAT, 32'h202, 32'h2);
    @(posedge clk);
    ev.tx_shift_busy <= 1'b0;
    pe('{timeout_hit: 1'b1, default: 1'b0});
    rc("timeout off", `OFS_CHAN_STAT, 32'h302, 32'h202);
    wr(`OFS_TIMEOUT, 32'h5);
    pc('{start_timeout_cmd: 1'b1, default: 1'b0});
    pe('{rx_char_done: 1'b1, default: 1'b0});
    pe('{timeout_hit: 1'b1, default: 1'b0});
    rc("timeout", `OFS_CHAN_STAT, 32'h100, 32'h100);
    pc('{start_timeout_cmd: 1'b1, default: 1'b0});
    rc("timeout cleared", `OFS_CHAN_STAT, 32'h100, 32'h0);
    // Card traffic: one plain NACK, one inhibited, then a limit of two.
    z = nacks;
    wr(`OFS_MODE, 32'h00000004);
    pe('{parity_err: 1'b1, default: 1'b0});
    wr(`OFS_MODE, 32'h00100004);
    pe('{parity_err: 1'b1, default: 1'b0});
    wr(`OFS_MODE, 32'h02200004);
    pe('{rx_char_done: 1'b1, default: 1'b0});
    repeat (3) pe('{parity_err: 1'b1, default: 1'b0});
    repeat (2) @(posedge clk);
    #1 chk("nack count", 32'(z + 3), 32'(nacks));
    rc("iteration", `OFS_CHAN_STAT, 32'h400, 32'h400);
    wr(`OFS_MODE, 32'h0);
    pc('{reset_iterations_cmd: 1'b1, default: 1'b0});
    rc("iteration kept", `OFS_CHAN_STAT, 32'h400, 32'h400);
    wr(`OFS_MODE, 32'h00000004);
    pc('{reset_iterations_cmd: 1'b1, default: 1'b0});
    rc("iteration cleared", `OFS_CHAN_STAT, 32'h400, 32'h0);
    pe('{nack_seen: 1'b1, default: 1'b0});
    rc("nack flag", `OFS_CHAN_STAT, 32'h2000, 32'h2000);
    pc('{reset_nack_cmd: 1'b1, default: 1'b0});
    rc("nack cleared", `OFS_CHAN_STAT, 32'h2000, 32'h0);
    // In the second card protocol every parity error is answered unless inhibited.
    z = nacks;
    wr(`OFS_MODE, 32'h02200006);
    pe('{parity_err: 1'b1, default: 1'b0});
    repeat (2) @(posedge clk);
    #1 chk("second protocol nack", 32'(z + 1), 32'(nacks));
    @(posedge clk);
    modem_req <= 4'hF;
    repeat (3) @(posedge clk);
    rc("modem change", `OFS_CHAN_STAT, 32'h00FF0000, 32'h00FF0000);
    rc("modem live", `OFS_CHAN_STAT, 32'h00FF0000, 32'h00F00000);
    // A low spell shorter than one sample period must not get through the filter.
    wr(`OFS_MODE, 32'h10000000);
    repeat (64) @(posedge clk);
    line_req <= 1'b0;
    z = 0;
    repeat (10) @(posedge clk);
    line_req <= 1'b1;
    repeat (48) begin
      @(posedge clk);
      #1 if (rx_filt !== 1'b1) z++;
    end
    chk("glitch", 32'h0, 32'(z));
    @(posedge clk);
    line_req <= 1'b0;
    repeat (80) @(posedge clk);
    #1 chk("filtered low", 32'h0, {31'h0, rx_filt});
    wr(`OFS_MODE, 32'h0);
    @(posedge clk);
    line_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("raw line", 32'h1, {31'h0, rx_filt});
    final_report();
  end
endmodule

// ### testbench/usart_status_sva.sv
// Port-level assertions of the serial status block.
`timescale 1ns/10ps
`include "usart_status_defs.svh"
module usart_status_chk (
  input wire logic                        core_clk_i,
  input wire logic                        rst_n_i,
  input wire usart_status_pkg::reg_req_t  bus_i,
  input wire usart_status_pkg::line_evt_t evt_i,
  input wire usart_status_pkg::cmd_t      cmd_i,
  input wire logic                        rx_line_i,
  input wire logic [31:0]                 rdata_o,
  input wire logic                        irq_o,
  input wire logic                        nack_drive_o,
  input wire logic                        rx_filtered_o
);
  import usart_status_pkg::*;
  logic [31:0] mode_r;
  logic [31:0] mask_r;
  logic        stat_rd;
  logic        card;

  // Shadow copies of mode and mask, kept from the bus writes alone.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= 32'h0;
      mask_r <= 32'h0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `OFS_MODE) begin
        mode_r <= bus_i.wdata;
      end
      if (bus_i.addr == `OFS_IRQ_SET) begin
        mask_r <= mask_r | (bus_i.wdata & `IRQ_BITS);
      end
      if (bus_i.addr == `OFS_IRQ_CLR) begin
        mask_r <= mask_r & ~bus_i.wdata;
      end
    end
  end

  assign stat_rd = bus_i.rd && (bus_i.addr == `OFS_CHAN_STAT);
  assign card    = (mode_r[3:0] == `MODE_T0) || (mode_r[3:0] == `MODE_T1);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_inhibit_nack: assert property (
    mode_r[`MODE_NACK_INHIBIT] |=> !nack_drive_o) else $error("nack driven while inhibited");
  a_parity_nack: assert property (
    evt_i.parity_err && card && !mode_r[`MODE_NACK_INHIBIT]
    && (!mode_r[`MODE_NACK_COUNT] || mode_r[3:0] == `MODE_T1)
    |=> nack_drive_o) else $error("no nack after parity error");
  a_nack_cause: assert property (
    nack_drive_o |-> $past(evt_i.parity_err)) else $error("nack without parity error");
  a_mask_read: assert property (
    bus_i.rd && bus_i.addr == `OFS_IRQ_MASK |=> rdata_o == $past(mask_r)) else $error("mask view wrong");
  a_irq_masked: assert property (
    mask_r == 32'h0 && !(bus_i.wr && bus_i.addr == `OFS_IRQ_SET) |=> !irq_o) else $error("irq with empty mask");
  a_dma_mirror: assert property (
    stat_rd |=> {rdata_o[12:11], rdata_o[4:3]} == $past({evt_i.rx_dma_buffer_full, evt_i.tx_dma_buffer_empty,
    evt_i.tx_dma_done, evt_i.rx_dma_done}, 2)) else $error("dma status bits wrong");
  a_modem_live: assert property (
    stat_rd && $stable({evt_i.clear_to_send, evt_i.carrier, evt_i.set_ready, evt_i.ring})
    |=> rdata_o[23:20] == $past({evt_i.clear_to_send, evt_i.carrier, evt_i.set_ready, evt_i.ring}))
    else $error("modem levels wrong");
  a_parity_sticky: assert property (
    evt_i.parity_err ##1 !cmd_i.status_reset_cmd ##1 stat_rd |=> rdata_o[`BIT_PAR])
    else $error("parity flag lost");
  a_rdata_idle: assert property (
    !bus_i.rd |=> rdata_o == 32'h0) else $error("read data outside read cycle");
  a_unmapped_zero: assert property (
    bus_i.rd && bus_i.addr == 8'hF0 |=> rdata_o == 32'h0) else $error("unmapped read not zero");

  cover property (nack_drive_o);
  cover property (irq_o);
  cover property (stat_rd ##1 rdata_o[`BIT_RIC]);
endmodule

bind usart_status usart_status_chk chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
  .evt_i(evt_i), .cmd_i(cmd_i), .rx_line_i(rx_line_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .nack_drive_o(nack_drive_o), .rx_filtered_o(rx_filtered_o));
